// *** rtl/mfcv_flow_vlan.v ***
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "mfcv_consts.vh"
module mfcv_flow_vlan (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [11:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output reg  [1:0]  avs_response,
    input  wire        rx_valid,
    input  wire        rx_sof,
    input  wire        rx_eof,
    input  wire [7:0]  rx_data,
    input  wire        rx_fcs_ok,
    input  wire        rx_addr_pass,
    output reg         rx_out_valid,
    output reg         rx_out_sof,
    output reg         rx_out_eof,
    output reg  [7:0]  rx_out_data,
    output reg         rx_stat_valid,
    output reg         rx_stat_filter,
    output reg         rx_stat_vlan_tag_first,
    output reg         rx_stat_vlan_tag_second,
    output reg         rx_stat_len_err,
    output reg         rx_stat_ctrl,
    output wire [15:0] coe_vlan_type,
    output wire        tx_hold,
    output reg         tx_pause_req,
    output reg  [15:0] tx_pause_time,
    input  wire        tx_pause_done,
    input  wire        carrier_in,
    output reg         back_pressure
);
    reg [31:16] pause_time_value_q;
    reg         pass_control_frames_q;
    reg         pause_handling_enable_q;
    reg         pause_tx_busy_q;
    reg [15:0]  tag_identifier_first_q;
    reg [15:0]  tag_identifier_second_q;
    reg         full_duplex_q;
    reg         speed_100_q;
    reg         promisc_q;
    reg         ack_q;
    reg [10:0]  byte_cnt_q;
    reg [15:0]  type_q;
    reg [15:0]  opc_q;
    reg [15:0]  rx_pt_q;
    reg [15:0]  quanta_q;
    reg [13:0]  slot_cnt_q;
    reg [11:0]  bp_cnt_q;
    reg         crs_s1_q;
    reg         crs_s2_q;
    reg         send_q;
    wire        vlan_tag_first_hit;
    wire        vlan_tag_second_hit;
    wire        is_pause;
    wire        fc_active;
    wire [13:0] slot_cyc;
    wire        acc;
    wire        wr_go;
    wire        rd_go;

    localparam [13:0] SLOT_10  = `MFCV_QUANTUM_CYC_10;
    localparam [13:0] SLOT_100 = `MFCV_QUANTUM_CYC_100;

    // one wait cycle, answer on second edge
    assign acc             = (avs_read | avs_write) & ~ack_q;
    assign avs_waitrequest = ~ack_q;
    assign wr_go           = avs_write & ack_q;
    assign rd_go           = avs_read & ack_q;
    assign coe_vlan_type   = tag_identifier_first_q;
    assign fc_active       = pause_handling_enable_q;
    assign slot_cyc        = speed_100_q ? SLOT_100 : SLOT_10;
    assign tx_hold         = (quanta_q != 16'h0000);

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ack_q <= 1'b0;
        else
            ack_q <= acc;
    end

    // register writes
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pause_time_value_q      <= `MFCV_PT_RST;
            pass_control_frames_q   <= 1'b0;
            pause_handling_enable_q <= 1'b0;
            tag_identifier_first_q  <= `MFCV_TAG_RST;
            tag_identifier_second_q <= `MFCV_TAG_RST;
            full_duplex_q           <= 1'b0;
            speed_100_q             <= 1'b0;
            promisc_q               <= 1'b0;
            send_q                  <= 1'b0;
        end else begin
            send_q <= 1'b0;
            if (wr_go) begin
                case (avs_address)
                    `MFCV_OFF_FLOW: begin
                        if (avs_byteenable[3])
                            pause_time_value_q[31:24] <= avs_writedata[31:24];
                        if (avs_byteenable[2])
                            pause_time_value_q[23:16] <= avs_writedata[23:16];
                        if (avs_byteenable[0]) begin
                            pass_control_frames_q   <= avs_writedata[`MFCV_FLOW_PASS];
                            pause_handling_enable_q <= avs_writedata[`MFCV_FLOW_EN];
                        end
                    end
                    `MFCV_OFF_VLAN_TAG_FIRST: begin
                        if (avs_byteenable[1])
                            tag_identifier_first_q[15:8] <= avs_writedata[15:8];
                        if (avs_byteenable[0])
                            tag_identifier_first_q[7:0] <= avs_writedata[7:0];
                    end
                    `MFCV_OFF_VLAN_TAG_SECOND: begin
                        if (avs_byteenable[1])
                            tag_identifier_second_q[15:8] <= avs_writedata[15:8];
                        if (avs_byteenable[0])
                            tag_identifier_second_q[7:0] <= avs_writedata[7:0];
                    end
                    `MFCV_OFF_CTRL: begin
                        if (avs_byteenable[0]) begin
                            full_duplex_q <= avs_writedata[`MFCV_CTRL_FDX];
                            speed_100_q   <= avs_writedata[`MFCV_CTRL_SPD100];
                            send_q        <= avs_writedata[`MFCV_CTRL_SEND];
                            promisc_q     <= avs_writedata[`MFCV_CTRL_PROMISC];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read mux and response
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
        end else if (acc) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'b00;
            case (avs_address)
                `MFCV_OFF_FLOW:
                    avs_readdata <= {pause_time_value_q, 13'h0000, pass_control_frames_q,
                                     pause_handling_enable_q, pause_tx_busy_q};
                `MFCV_OFF_VLAN_TAG_FIRST: avs_readdata <= {16'h0000, tag_identifier_first_q};
                `MFCV_OFF_VLAN_TAG_SECOND: avs_readdata <= {16'h0000, tag_identifier_second_q};
                `MFCV_OFF_CTRL:
                    avs_readdata <= {28'h0000000, promisc_q, 1'b0, speed_100_q, full_duplex_q};
                `MFCV_OFF_STAT:
                    avs_readdata <= {quanta_q, 14'h0000, back_pressure, tx_hold};
                default: avs_response <= 2'b10;
            endcase
        end
    end

    // receive byte counting and header capture
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_cnt_q <= 11'h000;
            type_q     <= 16'h0000;
            opc_q      <= 16'h0000;
            rx_pt_q    <= 16'h0000;
        end else if (rx_valid) begin
            if (rx_sof)
                byte_cnt_q <= 11'h001;
            else if (byte_cnt_q != 11'h7ff)
                byte_cnt_q <= byte_cnt_q + 11'h001;
            if (fc_active) begin
                if (byte_cnt_q == `MFCV_BYTE_TYPE_HI)
                    type_q[15:8] <= rx_data;
                if (byte_cnt_q == `MFCV_BYTE_TYPE_LO)
                    type_q[7:0] <= rx_data;
                if (byte_cnt_q == `MFCV_BYTE_OPC_HI)
                    opc_q[15:8] <= rx_data;
                if (byte_cnt_q == `MFCV_BYTE_OPC_LO)
                    opc_q[7:0] <= rx_data;
                if (byte_cnt_q == `MFCV_BYTE_PT_HI)
                    rx_pt_q[15:8] <= rx_data;
                if (byte_cnt_q == `MFCV_BYTE_PT_LO)
                    rx_pt_q[7:0] <= rx_data;
            end
        end
    end

    // bytes 13 and 14 are counts 12 and 13 from zero
    mfcv_tag_match u_tag1 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sof     (rx_valid & rx_sof),
        .hit_hi  (rx_valid & (byte_cnt_q == `MFCV_BYTE_TYPE_HI)),
        .hit_lo  (rx_valid & (byte_cnt_q == `MFCV_BYTE_TYPE_LO)),
        .data    (rx_data),
        .tag     (tag_identifier_first_q),
        .match_q (vlan_tag_first_hit)
    );

    mfcv_tag_match u_tag2 (
        .clk     (clk),
        .sys_rst (sys_rst),
        .sof     (rx_valid & rx_sof),
        .hit_hi  (rx_valid & (byte_cnt_q == `MFCV_BYTE_TYPE_HI)),
        .hit_lo  (rx_valid & (byte_cnt_q == `MFCV_BYTE_TYPE_LO)),
        .data    (rx_data),
        .tag     (tag_identifier_second_q),
        .match_q (vlan_tag_second_hit)
    );

    assign is_pause = fc_active && rx_fcs_ok && (type_q == `MFCV_TYPE_MACCTL)
                      && (opc_q == `MFCV_OPC_PAUSE);

    // data passthrough and end-of-frame status
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_out_valid    <= 1'b0;
            rx_out_sof      <= 1'b0;
            rx_out_eof      <= 1'b0;
            rx_out_data     <= 8'h00;
            rx_stat_valid   <= 1'b0;
            rx_stat_filter  <= 1'b0;
            rx_stat_vlan_tag_first   <= 1'b0;
            rx_stat_vlan_tag_second   <= 1'b0;
            rx_stat_len_err <= 1'b0;
            rx_stat_ctrl    <= 1'b0;
        end else begin
            rx_out_valid  <= rx_valid;
            rx_out_sof    <= rx_valid & rx_sof;
            rx_out_eof    <= rx_valid & rx_eof;
            rx_out_data   <= rx_data;
            rx_stat_valid <= rx_valid & rx_eof;
            if (rx_valid & rx_eof) begin
                rx_stat_vlan_tag_first   <= vlan_tag_first_hit;
                rx_stat_vlan_tag_second   <= vlan_tag_second_hit;
                rx_stat_len_err <= (byte_cnt_q >= ((vlan_tag_first_hit | vlan_tag_second_hit) ?
                                   `MFCV_LEN_VLAN : `MFCV_LEN_STD));
                rx_stat_ctrl    <= is_pause;
                if (promisc_q)
                    rx_stat_filter <= 1'b1;
                else if (is_pause)
                    rx_stat_filter <= pass_control_frames_q;
                else
                    rx_stat_filter <= rx_addr_pass;
            end
        end
    end

    // pause timer, full duplex only
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            quanta_q   <= 16'h0000;
            slot_cnt_q <= 14'h0000;
        end else if (!full_duplex_q || !fc_active) begin
            quanta_q   <= 16'h0000;
            slot_cnt_q <= 14'h0000;
        end else if (rx_valid && rx_eof && is_pause) begin
            quanta_q   <= rx_pt_q;
            slot_cnt_q <= 14'h0000;
        end else if (quanta_q != 16'h0000) begin
            if (slot_cnt_q == slot_cyc - 14'h0001) begin
                slot_cnt_q <= 14'h0000;
                quanta_q   <= quanta_q - 16'h0001;
            end else begin
                slot_cnt_q <= slot_cnt_q + 14'h0001;
            end
        end
    end

    // pause send request, back pressure and busy
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            crs_s1_q        <= 1'b0;
            crs_s2_q        <= 1'b0;
            bp_cnt_q        <= 12'h000;
            back_pressure   <= 1'b0;
            tx_pause_req    <= 1'b0;
            tx_pause_time   <= 16'h0000;
            pause_tx_busy_q <= 1'b0;
        end else begin
            crs_s1_q <= carrier_in;
            crs_s2_q <= crs_s1_q;
            if (full_duplex_q && fc_active && send_q && !pause_tx_busy_q) begin
                tx_pause_req  <= 1'b1;
                tx_pause_time <= pause_time_value_q;
            end else if (tx_pause_done) begin
                tx_pause_req <= 1'b0;
            end
            if (!full_duplex_q && fc_active && crs_s2_q) begin
                back_pressure <= 1'b1;
                bp_cnt_q      <= `MFCV_BP_CYCLES;
            end else if (bp_cnt_q != 12'h000) begin
                bp_cnt_q <= bp_cnt_q - 12'h001;
            end else begin
                back_pressure <= 1'b0;
            end
            pause_tx_busy_q <= (tx_pause_req & ~tx_pause_done) | back_pressure
                               | (full_duplex_q & fc_active & send_q);
        end
    end
endmodule // mfcv_flow_vlan
`default_nettype wire

// *** rtl/mfcv_consts.vh ***
`ifndef MFCV_CONSTS_VH
`define MFCV_CONSTS_VH

`define MFCV_OFF_FLOW      12'h11c
`define MFCV_OFF_VLAN_TAG_FIRST     12'h120
`define MFCV_OFF_VLAN_TAG_SECOND     12'h124
`define MFCV_OFF_CTRL      12'h130
`define MFCV_OFF_STAT      12'h134

`define MFCV_FLOW_PT_HI    31
`define MFCV_FLOW_PT_LO    16
`define MFCV_FLOW_PASS     2
`define MFCV_FLOW_EN       1
`define MFCV_FLOW_BSY      0
`define MFCV_CTRL_FDX      0
`define MFCV_CTRL_SPD100   1
`define MFCV_CTRL_SEND     2
`define MFCV_CTRL_PROMISC  3

`define MFCV_TAG_RST       16'hffff
`define MFCV_PT_RST        16'h0000
`define MFCV_LEN_STD       11'd1518
`define MFCV_LEN_VLAN      11'd1522

`define MFCV_TYPE_MACCTL   16'h8808
`define MFCV_OPC_PAUSE     16'h0001
`define MFCV_BYTE_TYPE_HI  11'd12
`define MFCV_BYTE_TYPE_LO  11'd13
`define MFCV_BYTE_OPC_HI   11'd14
`define MFCV_BYTE_OPC_LO   11'd15
`define MFCV_BYTE_PT_HI    11'd16
`define MFCV_BYTE_PT_LO    11'd17

`define MFCV_LINK_CLK_HZ   40000000
`define MFCV_BIT_NS_10     100
`define MFCV_BIT_NS_100    10
`define MFCV_CLK_NS        25
`define MFCV_QUANTUM_BITS  512
`define MFCV_QUANTUM_CYC_10  ((`MFCV_QUANTUM_BITS * `MFCV_BIT_NS_10) / `MFCV_CLK_NS)
`define MFCV_QUANTUM_CYC_100 ((`MFCV_QUANTUM_BITS * `MFCV_BIT_NS_100) / `MFCV_CLK_NS)
`define MFCV_PAUSE_FRAME_BYTES 8'd64
`define MFCV_BP_CYCLES     12'd200

`endif

// *** rtl/mfcv_tag_match.v ***
`timescale 1ns/100ps
`default_nettype none
module mfcv_tag_match (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        sof,
    input  wire        hit_hi,
    input  wire        hit_lo,
    input  wire [7:0]  data,
    input  wire [15:0] tag,
    output reg         match_q
);
    reg hi_ok_q;

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_ok_q <= 1'b0;
            match_q <= 1'b0;
        end else begin
            if (sof)
                match_q <= 1'b0;
            if (hit_hi)
                hi_ok_q <= (data == tag[15:8]);
            if (hit_lo)
                match_q <= hi_ok_q && (data == tag[7:0]);
        end
    end
endmodule // mfcv_tag_match
`default_nettype wire

// *** verification/mfcv_phy_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module mfcv_phy_model (
    input  wire logic       clk,
    output var  logic       rx_valid,
    output var  logic       rx_sof,
    output var  logic       rx_eof,
    output wire logic [7:0] rx_data,
    output wire logic       rx_fcs_ok,
    input  wire logic       tx_pause_req,
    output var  logic       tx_pause_done,
    input  wire logic [7:0] done_delay
);
    logic [7:0] byte_q = 8'h00;
    logic [7:0] idle_q = 8'h5a;
    logic [7:0] cnt_q  = 8'h00;
    logic       fcs_q  = 1'b0;
    initial {rx_valid, rx_sof, rx_eof, tx_pause_done} = 4'h0;
    // idle lines toggle between 5a and a5 instead of holding the last frame byte
    assign rx_data   = rx_valid ? byte_q : idle_q;
    assign rx_fcs_ok = rx_eof ? fcs_q : ~fcs_q;
    always @(posedge clk) begin
        idle_q <= ~idle_q;
        tx_pause_done <= 1'b0;
        if (!tx_pause_req) cnt_q <= 8'h00;
        else if (cnt_q == done_delay) begin
            tx_pause_done <= 1'b1;
            cnt_q <= cnt_q + 8'h01;
        end else if (cnt_q < done_delay) cnt_q <= cnt_q + 8'h01;
    end
    task send(input int len, input logic [15:0] typ, input logic [15:0] pt, input logic fcs, input logic [7:0] salt);
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_sof <= (i == 0);
            rx_eof <= (i == len - 1);
            fcs_q <= fcs;
            byte_q <= (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : (i == 14) ? 8'h00 : (i == 15) ? 8'h01 :
                      (i == 16) ? pt[15:8] : (i == 17) ? pt[7:0] : salt ^ i[7:0];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_sof <= 1'b0;
        rx_eof <= 1'b0;
    endtask
endmodule // mfcv_phy_model
`default_nettype wire

// *** verification/mfcv_flow_vlan_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module mfcv_flow_vlan_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [11:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic        rx_valid,
    input wire logic        rx_sof,
    input wire logic        rx_eof,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_out_valid,
    input wire logic [7:0]  rx_out_data,
    input wire logic        rx_stat_valid,
    input wire logic        rx_stat_vlan_tag_first,
    input wire logic        rx_stat_vlan_tag_second,
    input wire logic        rx_stat_len_err,
    input wire logic        rx_stat_ctrl,
    input wire logic [15:0] coe_vlan_type,
    input wire logic        tx_hold,
    input wire logic        tx_pause_req,
    input wire logic        tx_pause_done
);
    logic [10:0] len_q;
    wire logic   mapped = avs_address inside {12'h11c, 12'h120, 12'h124, 12'h130, 12'h134};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // byte count of the frame in flight, first byte counts as one
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) len_q <= 11'd0;
        else if (rx_valid) len_q <= rx_sof ? 11'd1 : len_q + 11'd1;
    end
    rx_forward_a: assert property (rx_valid |=> rx_out_valid && rx_out_data == $past(rx_data))
        else $error("received byte not forwarded one cycle later");
    stat_at_eof_a: assert property (rx_valid && rx_eof |=> rx_stat_valid)
        else $error("no receive status after last byte");
    unmapped_resp_a: assert property (avs_read && !avs_waitrequest && !mapped |-> avs_readdata == 32'h0
        && avs_response == 2'b10) else $error("unmapped read not refused");
    coe_first_tag_a: assert property (avs_write && !avs_waitrequest && avs_address == 12'h120 && avs_byteenable == 4'hf
        |=> coe_vlan_type == $past(avs_writedata[15:0])) else $error("offload type differs from first tag");
    frame_len_a: assert property (rx_stat_valid |-> rx_stat_len_err == (len_q > ((rx_stat_vlan_tag_first || rx_stat_vlan_tag_second) ?
        11'd1522 : 11'd1518))) else $error("length error flag wrong for frame length");
    hold_cause_a: assert property ($rose(tx_hold) |-> rx_stat_valid && rx_stat_ctrl)
        else $error("transmit hold without a received control frame");
    req_stands_a: assert property (tx_pause_req && !tx_pause_done |=> tx_pause_req)
        else $error("pause request dropped before done");
    req_drop_a: assert property (tx_pause_req && tx_pause_done |=> !tx_pause_req)
        else $error("pause request kept after done");
    cover property ($rose(tx_hold));
    cover property (rx_stat_valid && rx_stat_vlan_tag_first);
    cover property (tx_pause_req && tx_pause_done);
endmodule // mfcv_flow_vlan_chk
bind mfcv_flow_vlan mfcv_flow_vlan_chk u_mfcv_flow_vlan_chk (.*);
`default_nettype wire

// *** verification/mfcv_flow_vlan_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", n, e, g); end end
module mfcv_flow_vlan_bench;
    typedef struct packed {
        logic [31:0] flow;
        logic [3:0]  ctrl;
        logic [10:0] len;
        logic [15:0] typ;
        logic        fcs;
        logic [9:0]  st;
        logic [11:0] hold;
    } mfcv_case_t;
    logic        clk, sys_rst, avs_read, avs_write, rx_addr_pass, carrier_in, preq_q;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, rnd;
    logic [3:0]  avs_byteenable;
    logic [7:0]  done_delay;
    wire  [31:0] avs_readdata;
    wire  [1:0]  avs_response;
    wire  [15:0] coe_vlan_type, tx_pause_time;
    wire  [7:0]  rx_data, rx_out_data;
    wire         avs_waitrequest, rx_valid, rx_sof, rx_eof, rx_fcs_ok, rx_out_valid, rx_out_sof, rx_out_eof;
    wire         rx_stat_valid, rx_stat_filter, rx_stat_vlan_tag_first, rx_stat_vlan_tag_second, rx_stat_len_err, rx_stat_ctrl;
    wire         tx_hold, tx_pause_req, tx_pause_done, back_pressure;
    int          failures = 0, total_checks = 0, hc = 0;
    logic [9:0]  sq[$];
    logic [31:0] rq[$];
    int          hq[$];
    logic [15:0] pq[$];
    // status note: {mask, value} over {filter, vlan_tag_first, vlan_tag_second, len_err, ctrl}
    mfcv_case_t  tbl [11] = '{
        '{32'h0002_0006, 4'h3, 11'd64, 16'h8808, 1'b1, 10'h3f1, 12'd408},
        '{32'h0001_0002, 4'h3, 11'd64, 16'h8808, 1'b1, 10'h3e1, 12'd204},
        '{32'h0001_0002, 4'hb, 11'd64, 16'h8808, 1'b1, 10'h210, 12'd204},
        '{32'h0001_0000, 4'h3, 11'd64, 16'h8808, 1'b1, 10'h3e0, 12'd0},
        '{32'h0001_0002, 4'h2, 11'd64, 16'h8808, 1'b1, 10'h1c0, 12'd0},
        '{32'h0001_0002, 4'h3, 11'd64, 16'h8808, 1'b0, 10'h3c0, 12'd0},
        '{32'h0001_0002, 4'h3, 11'd1521, 16'h8100, 1'b1, 10'h3e8, 12'd0},
        '{32'h0001_0002, 4'h3, 11'd1522, 16'h88a8, 1'b1, 10'h3e4, 12'd0},
        '{32'h0001_0002, 4'h3, 11'd1518, 16'h0800, 1'b1, 10'h3e0, 12'd0},
        '{32'h0001_0002, 4'h3, 11'd1519, 16'h0800, 1'b1, 10'h3e2, 12'd0},
        '{32'h0001_0006, 4'h1, 11'd64, 16'h8808, 1'b1, 10'h3f1, 12'd2048}
    };
    mfcv_flow_vlan u_mfcv_flow_vlan (.*);
    mfcv_phy_model u_mfcv_phy_model (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task bus(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest && n < 50);
        if (avs_waitrequest) begin
            failures++;
            end_of_test();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hf);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(a, 1'b0, 32'h0, 4'hf);
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        logic [9:0]  s;
        logic [31:0] e;
        logic [15:0] p;
        int          h;
        if (avs_read && !avs_waitrequest) begin
            e = rq.pop_front();
            `CHK("readdata", e, avs_readdata)
        end
        if (rx_stat_valid) begin
            s = sq.pop_front();
            `CHK("rx_status", s[4:0], s[9:5] & {rx_stat_filter, rx_stat_vlan_tag_first, rx_stat_vlan_tag_second, rx_stat_len_err, rx_stat_ctrl})
        end
        hc <= tx_hold ? hc + 1 : 0;
        if (!tx_hold && hc != 0) begin
            h = (hq.size() != 0) ? hq.pop_front() : 0;
            `CHK("hold_cycles", h, hc)
        end
        preq_q <= tx_pause_req;
        if (tx_pause_req && !preq_q) begin
            p = pq.pop_front();
            `CHK("pause_time", p, tx_pause_time)
        end
    end
    initial begin
        {sys_rst, avs_read, avs_write, carrier_in} = 4'h8;
        {avs_address, avs_writedata, avs_byteenable, done_delay} = '0;
        rx_addr_pass = 1'b0;
        rnd = 32'hd047;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rd(12'h11c, 32'h0);
        rd(12'h120, 32'hffff);
        rd(12'h124, 32'hffff);
        rd(12'h200, 32'h0);
        bus(12'h11c, 1'b1, 32'h1234_5678, 4'hc);
        rd(12'h11c, 32'h1234_0000);
        // first tag changed only while the receive path is idle
        wr(12'h120, 32'h8100);
        wr(12'h124, 32'h88a8);
        rd(12'h120, 32'h8100);
        rd(12'h124, 32'h88a8);
        for (int i = 0; i < 11; i++) begin
            wr(12'h11c, tbl[i].flow);
            rd(12'h11c, tbl[i].flow);
            wr(12'h130, {28'h0, tbl[i].ctrl});
            rnd = lfsr(rnd);
            sq.push_back(tbl[i].st);
            if (tbl[i].hold != 0) hq.push_back(int'(tbl[i].hold));
            u_mfcv_phy_model.send(int'(tbl[i].len), tbl[i].typ, tbl[i].flow[31:16], tbl[i].fcs, rnd[7:0]);
            repeat (int'(tbl[i].hold) + 20) @(posedge clk);
        end
        // address filter result carried through for a plain frame
        rx_addr_pass <= 1'b1;
        sq.push_back(10'h3f0);
        u_mfcv_phy_model.send(64, 16'h0800, 16'h0000, 1'b1, 8'h3c);
        repeat (5) @(posedge clk);
        for (int k = 0; k < 2; k++) begin
            done_delay <= k ? 8'd0 : 8'd40;
            wr(12'h11c, 32'h00a5_0002);
            pq.push_back(16'h00a5);
            wr(12'h130, 32'h7);
            repeat (2) @(posedge clk);
            if (k == 0) rd(12'h11c, 32'h00a5_0003);
            repeat (60) @(posedge clk);
            rd(12'h11c, 32'h00a5_0002);
        end
        wr(12'h130, 32'h2);
        wr(12'h11c, 32'h0001_0002);
        carrier_in <= 1'b1;
        repeat (20) @(posedge clk);
        rd(12'h134, 32'h2);
        rd(12'h11c, 32'h0001_0003);
        carrier_in <= 1'b0;
        repeat (240) @(posedge clk);
        rd(12'h134, 32'h0);
        rd(12'h11c, 32'h0001_0002);
        repeat (5) @(posedge clk);
        end_of_test();
    end
endmodule // mfcv_flow_vlan_bench
`default_nettype wire
